/* File: rtl/msc_pkg.sv */
// Package for the motor start-up configuration register bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package msc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int MSC_ADDR_W = 12;
  // Printed offset is a word index, byte address is four times it
  localparam logic [MSC_ADDR_W-1:0] MSC_CFG1_IDX = 12'h082;
  localparam logic [MSC_ADDR_W-1:0] MSC_CFG1_ADDR = 12'h208;
  localparam logic [31:0] MSC_CFG1_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions (low bit of each field)
  // ----------------------------------------------------------------
  localparam int MSC_PARITY_POS = 31;
  localparam int MSC_METHOD_POS = 29;
  localparam int MSC_RAMP_POS = 25;
  localparam int MSC_HOLD_TIME_POS = 21;
  localparam int MSC_HOLD_LIM_POS = 17;
  localparam int MSC_PD_RATE_POS = 14;
  localparam int MSC_PD_LIM_POS = 10;
  localparam int MSC_RELEASE_POS = 8;
  localparam int MSC_ANGLE_POS = 6;
  localparam int MSC_REPEAT_POS = 4;
  localparam int MSC_FIRST_POS = 0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSC_START_HOLD = 2'h0,
    MSC_START_DOUBLE_HOLD = 2'h1,
    MSC_START_POSITION_DETECT = 2'h2,
    MSC_START_SLOW_FIRST = 2'h3
  } msc_method_t;

  localparam logic [3:0] MSC_HOLD_LIM_NA = 4'h0;
  localparam logic [3:0] MSC_PD_LIM_MIN = 4'h2;
  localparam logic [1:0] MSC_REL_BRAKE = 2'h0;
  localparam logic [1:0] MSC_REL_TRISTATE = 2'h1;
  localparam logic [3:0] MSC_FIRST_RESERVED = 4'hA;

  // Whole word, layout matches the bit positions above
  typedef struct packed {
    logic parity;
    msc_method_t startup_method;
    logic [3:0] hold_ramp_rate;
    logic [3:0] hold_duration;
    logic [3:0] hold_current_limit;
    logic [2:0] pulse_detect_rate;
    logic [3:0] pulse_detect_current_limit;
    logic [1:0] pulse_detect_release_action;
    logic [1:0] pulse_detect_lead_angle;
    logic [1:0] pulse_detect_repeat_count;
    logic [3:0] first_cycle_rate;
  } msc_cfg_t;

  // Decoded qualifiers for the start-up sequencer
  typedef struct packed {
    logic hold_limit_valid;
    logic pulse_limit_valid;
    logic release_valid;
    logic first_rate_reserved;
  } msc_flags_t;

  typedef enum logic [2:0] {
    MSC_ST_IDLE = 3'b001,
    MSC_ST_RESP = 3'b010,
    MSC_ST_DONE = 3'b100
  } msc_state_t;

endpackage : msc_pkg

/* File: rtl/msc_startup_cfg.sv */
// APB register bank holding the first motor start-up configuration word.
// Assumes an APB master on sys_clk; all inputs synchronous to it.
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
//
// Operation
// - 32-bit word at index 82h, resets zero
// - Bits 30:29 pick start-up method
// - Bits 28:25 hold voltage ramp rate code
// - Bits 20:17 hold current limit, 0 unused
// - Bits 16:14 pulse detection clock rate
// - Bits 9:8 release: brake or tristate
// - Bits 7:6 lead angle 0-90 degrees
// - Bits 5:4 pulse detection repeat count
// - Bits 3:0 first cycle rate code
module msc_startup_cfg
  import msc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output msc_cfg_t cfg,
  output msc_flags_t flags
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, so read
  // data and error are registered before the master samples them.
  msc_state_t state_q, state_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic hit;
  logic commit;
  // Declared here because the read path returns the stored word
  msc_cfg_t cfg_q, cfg_d;

  assign hit = (paddr == MSC_CFG1_ADDR);
  assign commit = psel & penable & pready_q;

  always_comb begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (state_q)
      MSC_ST_IDLE: begin
        if (psel && penable) begin
          state_d = MSC_ST_RESP;
          pready_d = 1'b1;
          pslverr_d = ~hit;
          // Unmapped reads return zero
          prdata_d = (hit && !pwrite) ? cfg_q : 32'h00000000;
        end
      end
      MSC_ST_RESP: begin
        state_d = MSC_ST_DONE;
      end
      MSC_ST_DONE: begin
        state_d = MSC_ST_IDLE;
      end
      default: begin
        state_d = MSC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------
  msc_flags_t flags_q, flags_d;

  always_comb begin
    cfg_d = cfg_q;
    // Every field stored verbatim, including parity and code 10
    if (commit && pwrite && hit) begin
      cfg_d = msc_cfg_t'(pwdata);
    end
    flags_d.hold_limit_valid =
      (cfg_d.hold_current_limit != MSC_HOLD_LIM_NA);
    flags_d.pulse_limit_valid =
      (cfg_d.pulse_detect_current_limit >= MSC_PD_LIM_MIN);
    flags_d.release_valid =
      (cfg_d.pulse_detect_release_action == MSC_REL_BRAKE) ||
      (cfg_d.pulse_detect_release_action == MSC_REL_TRISTATE);
    flags_d.first_rate_reserved =
      (cfg_d.first_cycle_rate == MSC_FIRST_RESERVED);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= MSC_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      cfg_q <= msc_cfg_t'(MSC_CFG1_RESET);
      // Flags match the all-zero word: release code 0 is brake
      flags_q <= 4'h2;
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      cfg_q <= cfg_d;
      flags_q <= flags_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cfg = cfg_q;
  assign flags = flags_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reset value is only guaranteed until the first committed write
  logic written_q, written_d;
  always_comb begin
    written_d = written_q | (commit & pwrite & hit);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      written_q <= 1'b0;
    end else begin
      written_q <= written_d;
    end
  end

  sequence s_write;
    psel && penable && pready && pwrite && hit;
  endsequence

  sequence s_read_req;
    psel && penable && !pready && !pwrite && hit;
  endsequence

  property p_reset_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      !written_q |-> (cfg_q == MSC_CFG1_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("config word not zero before first write");

  property p_read_back;
    @(posedge sys_clk) disable iff (sys_rst)
      s_read_req ##1 (psel && penable) |->
        pready && !pslverr && (prdata == cfg_q);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data differs from stored word");

  property p_unmapped;
    @(posedge sys_clk) disable iff (sys_rst)
      (psel && penable && !pready && !hit) |=>
        pready && pslverr && (prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_method;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> (cfg.startup_method ==
        $past(pwdata[MSC_METHOD_POS+1:MSC_METHOD_POS]));
  endproperty
  a_method: assert property (p_method)
    else $error("start-up method not stored");

  property p_hold_fields;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=>
        (cfg.hold_ramp_rate == $past(pwdata[MSC_RAMP_POS+3:MSC_RAMP_POS]))
        && (cfg.hold_duration ==
          $past(pwdata[MSC_HOLD_TIME_POS+3:MSC_HOLD_TIME_POS]));
  endproperty
  a_hold_fields: assert property (p_hold_fields)
    else $error("hold ramp or duration not stored");

  property p_hold_limit;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> flags.hold_limit_valid ==
        ($past(pwdata[MSC_HOLD_LIM_POS+3:MSC_HOLD_LIM_POS]) != 4'h0);
  endproperty
  a_hold_limit: assert property (p_hold_limit)
    else $error("hold limit qualifier wrong");

  property p_pulse_fields;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=>
        (cfg.pulse_detect_rate ==
          $past(pwdata[MSC_PD_RATE_POS+2:MSC_PD_RATE_POS]))
        && (cfg.pulse_detect_lead_angle ==
          $past(pwdata[MSC_ANGLE_POS+1:MSC_ANGLE_POS]))
        && (cfg.pulse_detect_repeat_count ==
          $past(pwdata[MSC_REPEAT_POS+1:MSC_REPEAT_POS]));
  endproperty
  a_pulse_fields: assert property (p_pulse_fields)
    else $error("pulse detection fields not stored");

  property p_pulse_limit;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> flags.pulse_limit_valid ==
        ($past(pwdata[MSC_PD_LIM_POS+3:MSC_PD_LIM_POS]) > 4'h1);
  endproperty
  a_pulse_limit: assert property (p_pulse_limit)
    else $error("pulse limit qualifier wrong");

  property p_release;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> flags.release_valid ==
        !$past(pwdata[MSC_RELEASE_POS+1]);
  endproperty
  a_release: assert property (p_release)
    else $error("release qualifier wrong");

  property p_first_rate;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> (cfg.first_cycle_rate == $past(pwdata[3:0]))
        && (flags.first_rate_reserved == ($past(pwdata[3:0]) == 4'hA));
  endproperty
  a_first_rate: assert property (p_first_rate)
    else $error("first cycle rate or reserved flag wrong");

  property p_parity;
    @(posedge sys_clk) disable iff (sys_rst)
      s_write |=> (cfg.parity == $past(pwdata[MSC_PARITY_POS]))
        ##1 $stable(cfg.parity) || $past(commit);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit not stored as written");

  property p_no_write_stable;
    @(posedge sys_clk) disable iff (sys_rst)
      !(commit && pwrite && hit) |=> $stable(cfg_q);
  endproperty
  a_no_write_stable: assert property (p_no_write_stable)
    else $error("config word changed without a write");

endmodule : msc_startup_cfg

/* File: tb/tb.sv */
// Bench for the start-up configuration register bank over APB.
// Assumes msc_pkg and msc_startup_cfg compiled first; 100 MHz clock.
`timescale 1ns/100ps
module tb;
  import msc_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [MSC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  msc_cfg_t cfg;
  msc_flags_t flags;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int checks = 0;

  always #5 sys_clk = ~sys_clk;

  msc_startup_cfg i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .flags(flags));

  // ----------------------------------------------------------------
  // Verdict and compares
  // ----------------------------------------------------------------
  task automatic close_out;
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flags(input msc_flags_t got, input msc_flags_t exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t flags %b expected %b", $time, got, exp);
    end
  endtask : cmp_flags

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t error bit %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  function automatic msc_flags_t exp_flags(input logic [31:0] w);
    msc_flags_t f;
    f.hold_limit_valid = (w[20:17] != 4'h0);
    f.pulse_limit_valid = (w[13:10] >= 4'h2);
    f.release_valid = (w[9:8] < 2'h2);
    f.first_rate_reserved = (w[3:0] == 4'hA);
    return f;
  endfunction : exp_flags

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  // No fixed latency assumed; the wait is bounded to catch a hang
  task automatic apb(input logic wr, input logic [MSC_ADDR_W-1:0] a,
    input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("MISMATCH %0t no ready", $time);
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_word(input logic [31:0] w);
    apb(1'b1, MSC_CFG1_ADDR, w, rd, er);
    cmp_bit(er, 1'b0);
    @(negedge sys_clk);
    cmp_word(cfg, w);
    cmp_flags(flags, exp_flags(w));
    apb(1'b0, MSC_CFG1_ADDR, 32'h0, rd, er);
    cmp_bit(er, 1'b0);
    cmp_word(rd, w);
  endtask : do_word

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    cmp_word(cfg, MSC_CFG1_RESET);
    cmp_flags(flags, exp_flags(32'h0));
    sys_rst <= 1'b0;
    apb(1'b0, MSC_CFG1_ADDR, 32'h0, rd, er);
    cmp_word(rd, MSC_CFG1_RESET);
    do_word(32'h8000_0000);
    for (int i = 0; i < 4; i++) do_word(32'(i) << MSC_METHOD_POS);
    do_word(32'h0200_0000);
    do_word(32'h1E00_0000);
    do_word(32'h01E0_0000);
    do_word(32'h0002_0000);
    do_word(32'h001E_0000);
    do_word(32'h0001_C000);
    do_word(32'h0000_4000);
    do_word(32'h0000_0400);
    do_word(32'h0000_0800);
    do_word(32'h0000_3C00);
    for (int i = 0; i < 4; i++) do_word(32'(i) << MSC_RELEASE_POS);
    do_word(32'h0000_00C0);
    do_word(32'h0000_0040);
    do_word(32'h0000_0030);
    do_word(32'h0000_0010);
    for (int i = 0; i < 16; i++) do_word(32'(i));
    do_word(32'hFFFF_FFFF);
    // Printed offset used as a byte address must miss the word
    apb(1'b1, MSC_CFG1_IDX, 32'h1234_5678, rd, er);
    cmp_bit(er, 1'b1);
    @(negedge sys_clk);
    cmp_word(cfg, 32'hFFFF_FFFF);
    apb(1'b0, 12'h20C, 32'h0, rd, er);
    cmp_bit(er, 1'b1);
    cmp_word(rd, 32'h0);
    // Reset in mid-run clears the stored word
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    cmp_word(cfg, MSC_CFG1_RESET);
    cmp_flags(flags, exp_flags(32'h0));
    apb(1'b0, MSC_CFG1_ADDR, 32'h0, rd, er);
    cmp_word(rd, MSC_CFG1_RESET);
    close_out();
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : tb
